// file: logic/bld_pkg.sv
// Shared constants, encodings and helpers of the backlight control link.
// Assumes one 40 MHz clock shared by both ends.
package bld_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int SAMPLE_HZ = 20_000_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int T_WAIT_NS = 150_000;
  localparam int WAIT_CYC = (T_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_STEP_NS = 250;
  localparam int STEP_CYC = (T_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] STEP_CYC_W = 12'(STEP_CYC);
  localparam int LINK_TIMEOUT_CYC = 16;

  // ==========================================================
  // Duty measurement
  localparam int TOTAL_W = 18;
  localparam logic [10:0] DUTY_FULL = 11'h7FF;
  localparam logic [3:0] DIV_BITS = 4'hB;

  // ==========================================================
  // Device registers on the link
  localparam logic [7:0] OFS_MODE = 8'h02;
  localparam logic [7:0] OFS_PWM = 8'h06;
  localparam logic [7:0] OFS_RAMP = 8'h08;
  localparam logic [7:0] MODE_RST = 8'h98;
  localparam logic [7:0] PWM_RST = 8'h87;
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam int MODE_BL_BIT = 0;
  localparam int MODE_FS_LSB = 3;
  localparam int PWM_EN_BIT = 7;
  localparam int PWM_POL_BIT = 6;
  localparam int PWM_HYS_LSB = 3;
  localparam int RAMP_PWM_LSB = 4;

  // ==========================================================
  // Host registers on Avalon-MM (byte addresses)
  localparam logic [4:0] HOFS_CTRL = 5'h00;
  localparam logic [4:0] HOFS_PERIOD = 5'h04;
  localparam logic [4:0] HOFS_HIGH = 5'h08;
  localparam logic [4:0] HOFS_CMD = 5'h0C;
  localparam logic [4:0] HOFS_STAT = 5'h10;

  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    ST_SHUT = 4'h1,
    ST_STBY = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_RAMPDN = 4'h8
  } bld_dev_state_e;

  typedef enum logic [1:0] {
    HL_IDLE = 2'h1,
    HL_REQ = 2'h2
  } bld_host_state_e;

  // Hysteresis code to LSB count: twice the code
  function automatic logic [10:0] hys_lsbs(input logic [2:0] code);
    hys_lsbs = {7'h00, code, 1'b0};
  endfunction

endpackage

// file: logic/bld_link_if.sv
// Link between host and backlight device: enable, dimming pin, register port.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps

interface bld_link_if;
  logic hardware_enable_pin;
  logic pwm_pin;
  logic bus_req;
  logic bus_write;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_ack;
  logic [7:0] bus_rdata;

  modport dev (
    input hardware_enable_pin, pwm_pin, bus_req, bus_write, bus_addr, bus_wdata,
    output bus_ack, bus_rdata
  );

  modport host (
    output hardware_enable_pin, pwm_pin, bus_req, bus_write, bus_addr, bus_wdata,
    input bus_ack, bus_rdata
  );
endinterface

// file: logic/bld_duty_meter.sv
// Duty ratio meter: samples an active-high level at the sampling rate and
// reports active/total per period as an 11-bit ratio.
// Assumes active_in is synchronous to clk_in.
`timescale 1ns/1ps

module bld_duty_meter (
  input wire logic clk_in, // 40 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic clear_in, // Synchronous clear
  input wire logic active_in, // Pin level, already polarity corrected
  output logic [10:0] duty_out, // Last measured ratio
  output logic valid_out // One-cycle pulse on new ratio
);
  import bld_pkg::*;

  typedef struct packed {
    logic [3:0] div;
    logic prev;
    logic [TOTAL_W-1:0] act;
    logic [TOTAL_W-1:0] tot;
    logic [TOTAL_W-1:0] den;
    logic [TOTAL_W:0] rem;
    logic [10:0] q;
    logic [3:0] bits;
    logic busy;
    logic [10:0] duty;
    logic valid;
  } bld_meter_s;

  localparam bld_meter_s METER_RST = '0;

  bld_meter_s r_reg, r_next;
  logic strobe;
  logic [TOTAL_W:0] rem2;

  // ==========================================================
  // Sampling and serial division
  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    strobe = (r_reg.div == 4'(SAMPLE_DIV - 1));
    r_next.div = strobe ? 4'h0 : r_reg.div + 4'h1;
    rem2 = {r_reg.rem[TOTAL_W-1:0], 1'b0};
    // One quotient bit per clock; a period is far longer than 11 cycles
    if (r_reg.busy) begin
      if (rem2 >= {1'b0, r_reg.den}) begin
        r_next.rem = rem2 - {1'b0, r_reg.den};
        r_next.q = {r_reg.q[9:0], 1'b1};
      end else begin
        r_next.rem = rem2;
        r_next.q = {r_reg.q[9:0], 1'b0};
      end
      r_next.bits = r_reg.bits - 4'h1;
      if (r_reg.bits == 4'h1) begin
        r_next.busy = 1'b0;
        r_next.duty = r_next.q;
        r_next.valid = 1'b1;
      end
    end
    if (strobe) begin
      r_next.prev = active_in;
      if (active_in && !r_reg.prev) begin
        if (!r_reg.busy && r_reg.tot != '0) begin
          if (r_reg.act >= r_reg.tot) begin
            r_next.duty = DUTY_FULL;
            r_next.valid = 1'b1;
          end else begin
            r_next.busy = 1'b1;
            r_next.rem = {1'b0, r_reg.act};
            r_next.den = r_reg.tot;
            r_next.q = 11'h000;
            r_next.bits = DIV_BITS;
          end
        end
        r_next.act = {{(TOTAL_W-1){1'b0}}, 1'b1};
        r_next.tot = {{(TOTAL_W-1){1'b0}}, 1'b1};
      end else if ((&r_reg.tot) && !r_reg.busy) begin
        // No edge for too long: the pin is held, report 0 or full
        r_next.duty = r_reg.prev ? DUTY_FULL : 11'h000;
        r_next.valid = 1'b1;
        r_next.act = '0;
        r_next.tot = '0;
      end else begin
        r_next.act = r_reg.act + {{(TOTAL_W-1){1'b0}}, active_in};
        r_next.tot = r_reg.tot + {{(TOTAL_W-1){1'b0}}, 1'b1};
      end
    end
    if (clear_in) begin
      r_next = METER_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= METER_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign duty_out = r_reg.duty;
  assign valid_out = r_reg.valid;

endmodule // bld_duty_meter

// file: logic/bld_device.sv
// Device end: enable states, link registers and the dimming path that turns
// the dimming pin into a steady LED current level.
// Assumes the host end keeps the link handshake and the power-up wait.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// How it works
// - Enable low: shutdown, registers default, bus off
// - Shutdown: no acknowledge to any bus request
// - Enable high: standby, bus answers requests
// - Host waits 150 us after enable rise
// - Enable low cuts current at once
// - Backlight cleared: ramp down, bus stays alive
// - Mode bit 0 switches backlight mode
// - Mode bits 7:3 select full-scale current
// - Control bit 7 enables pin dimming
// - Dimming off: duty taken as full
// - Control bit 6 selects pin polarity
// - Pin sampled at 20 MHz
// - Duty becomes a steady, non-pulsing level
// - Host keeps active pulses at least 0.1 us
// - Host keeps pin between 100 Hz, 100 kHz
// - Duty changes ramp, slope from ramp bits 6:4
// - Duty is 11 bits, hysteresis from bits 5:3
// - Same direction follows; reversal needs hysteresis width
// - Hysteresis width is twice the code
// - Software picks hysteresis by pin frequency
// - Current scales by duty, or unity
module bld_device (
  input wire logic clk_in, // 40 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  bld_link_if.dev link, // Link from the host
  output logic bus_enabled_out, // Register port is live
  output logic led_enable_out, // Current sinks on
  output logic [4:0] full_scale_sink_current_out, // Full-scale current code
  output logic [10:0] dimming_duty_ratio_out, // Duty used for the current
  output logic [10:0] led_level_out, // Ramped current level, 2047 full
  output bld_pkg::bld_dev_state_e state_out // Present state
);
  import bld_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    bld_dev_state_e st;
    logic [7:0] mode;
    logic [7:0] pwmc;
    logic [7:0] ramp;
    logic ack;
    logic [7:0] rdata;
    logic up;
    logic [10:0] held;
    logic [10:0] duty;
    logic [10:0] level;
    logic [11:0] tick;
  } bld_dev_s;

  localparam bld_dev_s DEV_RST = '{
    st: ST_SHUT,
    mode: MODE_RST,
    pwmc: PWM_RST,
    ramp: RAMP_RST,
    ack: 1'b0,
    rdata: 8'h00,
    up: 1'b1,
    held: DUTY_FULL,
    duty: DUTY_FULL,
    level: 11'h000,
    tick: 12'h000
  };

  bld_dev_s r_reg, r_next;
  logic pin_active;
  logic meas_valid;
  logic [10:0] meas_duty;
  logic bus_on;
  logic take;
  logic backlight_on;
  logic [10:0] hys;
  logic [10:0] tgt;
  logic [11:0] interval;

  // ==========================================================
  // Duty measurement
  assign pin_active = link.pwm_pin ^ r_reg.pwmc[PWM_POL_BIT];

  bld_duty_meter u_meter (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(!link.hardware_enable_pin),
    .active_in(pin_active),
    .duty_out(meas_duty),
    .valid_out(meas_valid)
  );

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    bus_on = (r_reg.st != ST_SHUT);
    take = link.bus_req && !r_reg.ack && bus_on;
    backlight_on = r_reg.mode[MODE_BL_BIT];
    hys = hys_lsbs(r_reg.pwmc[PWM_HYS_LSB +: 3]);
    tgt = (r_reg.st == ST_ACTIVE) ? r_reg.duty : 11'h000;
    interval = STEP_CYC_W << r_reg.ramp[RAMP_PWM_LSB +: 3];

    // Register port: one-cycle acknowledge per request
    r_next.ack = take;
    if (take) begin
      if (link.bus_write) begin
        unique case (link.bus_addr)
          OFS_MODE: r_next.mode = link.bus_wdata;
          OFS_PWM: r_next.pwmc = link.bus_wdata;
          OFS_RAMP: r_next.ramp = link.bus_wdata;
          default: r_next.mode = r_reg.mode;
        endcase
      end else begin
        unique case (link.bus_addr)
          OFS_MODE: r_next.rdata = r_reg.mode;
          OFS_PWM: r_next.rdata = r_reg.pwmc;
          OFS_RAMP: r_next.rdata = r_reg.ramp;
          default: r_next.rdata = 8'h00;
        endcase
      end
    end

    // Hysteresis: a reversal must reach the programmed width
    if (meas_valid) begin
      if (meas_duty > r_reg.held) begin
        if (r_reg.up || (meas_duty - r_reg.held) >= hys) begin
          r_next.held = meas_duty;
          r_next.up = 1'b1;
        end
      end else if (meas_duty < r_reg.held) begin
        if (!r_reg.up || (r_reg.held - meas_duty) >= hys) begin
          r_next.held = meas_duty;
          r_next.up = 1'b0;
        end
      end
    end

    // Duty into the current: measured when dimming is on, else full
    r_next.duty = r_reg.pwmc[PWM_EN_BIT] ? r_reg.held : DUTY_FULL;

    // Fixed-slope ramp, so ramp time grows with the size of the change
    if (r_reg.level == tgt) begin
      r_next.tick = 12'h000;
    end else if (r_reg.tick >= interval - 12'h001) begin
      r_next.tick = 12'h000;
      if (r_reg.level < tgt) begin
        r_next.level = r_reg.level + 11'h001;
      end else begin
        r_next.level = r_reg.level - 11'h001;
      end
    end else begin
      r_next.tick = r_reg.tick + 12'h001;
    end

    unique case (r_reg.st)
      ST_SHUT: begin
        r_next.st = ST_STBY;
      end
      ST_STBY: begin
        if (backlight_on) begin
          r_next.st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!backlight_on) begin
          r_next.st = ST_RAMPDN;
        end
      end
      ST_RAMPDN: begin
        if (backlight_on) begin
          r_next.st = ST_ACTIVE;
        end else if (r_reg.level == 11'h000) begin
          r_next.st = ST_STBY;
        end
      end
      default: begin
        r_next.st = ST_SHUT;
      end
    endcase

    // Enable low overrides everything: no ramp, registers back to default
    if (!link.hardware_enable_pin) begin
      r_next = DEV_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= DEV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.bus_ack = r_reg.ack;
  assign link.bus_rdata = r_reg.rdata;
  assign bus_enabled_out = (r_reg.st != ST_SHUT);
  // The level is a held value, never the pin itself, so the current is DC
  assign led_level_out = r_reg.level;
  assign led_enable_out = (r_reg.st == ST_ACTIVE) || (r_reg.st == ST_RAMPDN);
  assign full_scale_sink_current_out = r_reg.mode[MODE_FS_LSB +: 5];
  assign dimming_duty_ratio_out = r_reg.duty;
  assign state_out = r_reg.st;

endmodule // bld_device

// file: logic/bld_host.sv
// Host end: Avalon-MM register slave that drives enable, generates the dimming
// pin and runs single register transfers on the link.
// Assumes one Avalon master and a device end on the same clock.
`timescale 1ns/1ps

module bld_host #(
  parameter int WAIT_CYCLES = bld_pkg::WAIT_CYC
) (
  input wire logic clk_in, // 40 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [4:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall
  bld_link_if.host link // Link to the device
);
  import bld_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic hw_en;
    logic pwm_run;
    logic [19:0] period;
    logic [19:0] high;
    logic [19:0] cnt;
    logic pwm;
    logic [15:0] wcnt;
    logic ready;
    bld_host_state_e st;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd8;
    logic [4:0] tmo;
    logic err;
  } bld_host_s;

  localparam bld_host_s HOST_RST = '{st: HL_IDLE, default: '0};

  bld_host_s r_reg, r_next;
  logic take;
  logic wr;

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    take = (avs_read_in || avs_write_in) && !r_reg.ack;
    wr = avs_write_in && r_reg.ack;
    r_next.ack = take;
    if (take) begin
      unique case (avs_address_in)
        HOFS_CTRL: r_next.rdata = {30'h0, r_reg.pwm_run, r_reg.hw_en};
        HOFS_PERIOD: r_next.rdata = {12'h000, r_reg.period};
        HOFS_HIGH: r_next.rdata = {12'h000, r_reg.high};
        HOFS_STAT: r_next.rdata = {16'h0000, r_reg.rd8, 4'h0, r_reg.hw_en,
                                   r_reg.err, r_reg.ready, (r_reg.st == HL_REQ)};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end

    // Dimming pin generator
    r_next.cnt = (r_reg.cnt >= r_reg.period - 20'h00001) ? 20'h00000 : r_reg.cnt + 20'h00001;
    r_next.pwm = r_reg.pwm_run && (r_reg.cnt < r_reg.high);

    // Power-up wait after enable rises
    if (!r_reg.hw_en) begin
      r_next.wcnt = 16'h0000;
      r_next.ready = 1'b0;
    end else if (!r_reg.ready) begin
      if (r_reg.wcnt == 16'(WAIT_CYCLES - 1)) begin
        r_next.ready = 1'b1;
      end else begin
        r_next.wcnt = r_reg.wcnt + 16'h0001;
      end
    end

    unique case (r_reg.st)
      HL_IDLE: begin
        if (wr && avs_address_in == HOFS_CMD) begin
          if (r_reg.ready && r_reg.hw_en) begin
            r_next.st = HL_REQ;
            r_next.req = 1'b1;
            r_next.we = avs_writedata_in[16];
            r_next.addr = avs_writedata_in[15:8];
            r_next.wdata = avs_writedata_in[7:0];
            r_next.tmo = 5'h00;
            r_next.err = 1'b0;
          end else begin
            r_next.err = 1'b1;
          end
        end
      end
      HL_REQ: begin
        if (link.bus_ack) begin
          r_next.req = 1'b0;
          r_next.rd8 = link.bus_rdata;
          r_next.st = HL_IDLE;
        end else if (r_reg.tmo == 5'(LINK_TIMEOUT_CYC - 1) || !r_reg.hw_en) begin
          // A silent device is shut down or absent
          r_next.req = 1'b0;
          r_next.err = 1'b1;
          r_next.st = HL_IDLE;
        end else begin
          r_next.tmo = r_reg.tmo + 5'h01;
        end
      end
      default: begin
        r_next.st = HL_IDLE;
      end
    endcase

    if (wr) begin
      unique case (avs_address_in)
        HOFS_CTRL: begin
          r_next.hw_en = avs_writedata_in[0];
          r_next.pwm_run = avs_writedata_in[1];
        end
        HOFS_PERIOD: r_next.period = avs_writedata_in[19:0];
        HOFS_HIGH: r_next.high = avs_writedata_in[19:0];
        default: r_next.hw_en = r_reg.hw_en;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= HOST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !r_reg.ack;
  assign avs_readdata_out = r_reg.rdata;
  assign link.hardware_enable_pin = r_reg.hw_en;
  assign link.pwm_pin = r_reg.pwm;
  assign link.bus_req = r_reg.req;
  assign link.bus_write = r_reg.we;
  assign link.bus_addr = r_reg.addr;
  assign link.bus_wdata = r_reg.wdata;

endmodule // bld_host

// file: tb/bld_link_checker.sv
// Concurrent checks on the host-device link.
// Assumes both ends share clk_in and rst_n_in; watches link signals only.
`timescale 1ns/1ps

module bld_link_checker #(
  parameter int WAIT_CYCLES = 6000
) (
  input wire logic clk_in, // Shared clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic hardware_enable_pin, // Enable from host
  input wire logic bus_req, // Request from host
  input wire logic bus_write, // Direction from host
  input wire logic [7:0] bus_addr, // Register offset
  input wire logic [7:0] bus_wdata, // Write byte
  input wire logic bus_ack, // Answer pulse from device
  input wire logic [7:0] bus_rdata // Read byte from device
);
  // ==========================================================
  // Cycles of enable high, saturating at the power-up wait
  int unsigned en_cnt_reg;
  int unsigned en_cnt_next;

  always_comb begin
    if (!hardware_enable_pin) en_cnt_next = 0;
    else if (en_cnt_reg < WAIT_CYCLES) en_cnt_next = en_cnt_reg + 1;
    else en_cnt_next = en_cnt_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) en_cnt_reg <= 0;
    else en_cnt_reg <= en_cnt_next;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_req_start;
    $rose(bus_req) && hardware_enable_pin;
  endsequence
  sequence s_ack_pulse;
    bus_ack ##1 (!bus_ack && !bus_req);
  endsequence

  property p_ack_answer; s_req_start |=> s_ack_pulse; endproperty
  property p_shut_quiet; !hardware_enable_pin |=> !bus_ack && bus_rdata == 8'h00; endproperty
  property p_first_cycle; $rose(hardware_enable_pin) |-> !bus_ack ##1 !bus_ack; endproperty
  property p_ack_cause; bus_ack |-> $past(bus_req) && $past(hardware_enable_pin); endproperty
  property p_wait; bus_req |-> en_cnt_reg >= WAIT_CYCLES; endproperty
  property p_hold;
    bus_req && !bus_ack ##1 bus_req |-> $stable(bus_addr) && $stable(bus_write)
      && $stable(bus_wdata);
  endproperty
  property p_rdata_hold;
    $changed(bus_rdata) && $past(hardware_enable_pin) |-> bus_ack && !$past(bus_write);
  endproperty
  property p_req_bounded; $rose(bus_req) |-> ##[1:17] !bus_req; endproperty

  a_ack_answer: assert property (p_ack_answer)
    else $error("link request not answered by a single ack");
  a_shut_quiet: assert property (p_shut_quiet)
    else $error("link active while enable low");
  a_first_cycle: assert property (p_first_cycle)
    else $error("ack in first cycle of enable");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_wait: assert property (p_wait)
    else $error("request before power-up wait");
  a_hold: assert property (p_hold)
    else $error("request fields changed while waiting");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read byte changed outside a read ack");
  a_req_bounded: assert property (p_req_bounded)
    else $error("request held too long");
endmodule // bld_link_checker

// file: tb/backlight_enable_pwm_dimming_tb.sv
// Self-checking bench: host and device ends joined by the link interface.
// Assumes a single Avalon master here and a shortened power-up wait.
`timescale 1ns/1ps

module backlight_enable_pwm_dimming_tb;
  import bld_pkg::*;
  localparam int WAIT_SHORT = 20;
  // Rows: we, offset, data, expected read byte
  localparam logic [24:0] REG_ROWS [0:5] = '{{1'b0, 8'h02, 8'h00, 8'h98},
    {1'b0, 8'h06, 8'h00, 8'h87}, {1'b0, 8'h08, 8'h00, 8'h00}, {1'b1, 8'h05, 8'hFF, 8'h00},
    {1'b0, 8'h05, 8'h00, 8'h00}, {1'b1, 8'h02, 8'h50, 8'h00}};
  // Rows: dimming control, period, active cycles, expected duty
  // Shortest period is 400 cycles, so the pin stays at or below 100 kHz
  localparam logic [42:0] DIM_ROWS [0:7] = '{{8'h07, 12'd400, 12'd100, 11'h7FF},
    {8'h80, 12'd400, 12'd100, 11'h200}, {8'hC0, 12'd400, 12'd100, 11'h600},
    {8'h80, 12'd2048, 12'd1024, 11'h400}, {8'h90, 12'd2048, 12'd1028, 11'h404},
    {8'h90, 12'd2048, 12'd1026, 11'h404}, {8'h88, 12'd2048, 12'd1026, 11'h402},
    {8'h90, 12'd2048, 12'd1024, 11'h400}};

  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bus_enabled;
  logic led_enable;
  logic [4:0] fs_code;
  logic [10:0] duty;
  logic [10:0] level;
  bld_dev_state_e dev_state;
  int err_total = 0;
  int n_compared = 0;
  int k;
  logic [31:0] st;
  logic [31:0] lv;

  bld_link_if link_if();
  bld_host #(.WAIT_CYCLES(WAIT_SHORT)) i_bld_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .link(link_if.host));
  bld_device i_bld_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_if.dev),
    .bus_enabled_out(bus_enabled), .led_enable_out(led_enable),
    .full_scale_sink_current_out(fs_code), .dimming_duty_ratio_out(duty),
    .led_level_out(level), .state_out(dev_state));
  bld_link_checker #(.WAIT_CYCLES(WAIT_SHORT)) i_bld_link_checker (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .hardware_enable_pin(link_if.hardware_enable_pin),
    .bus_req(link_if.bus_req), .bus_write(link_if.bus_write), .bus_addr(link_if.bus_addr),
    .bus_wdata(link_if.bus_wdata), .bus_ack(link_if.bus_ack), .bus_rdata(link_if.bus_rdata));

  always #12.5 clk_in = ~clk_in;

  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cycles(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One Avalon transfer; read data lands in st
  task av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Link transfer through the host, polled until not busy; status left in st
  task dev_cmd(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    av_xfer(1'b1, HOFS_CMD, {15'h0000, we, a, d});
    n = 0;
    do begin
      av_xfer(1'b0, HOFS_STAT, 32'h0);
      n++;
    end while (st[0] !== 1'b0 && n < 40);
    if (st[0] !== 1'b0) err_total++;
  endtask

  task print_verdict;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the whole run needs about 40k cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    print_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cycles(1);
    check(32'(dev_state), 32'(ST_SHUT));
    check({bus_enabled, led_enable, fs_code, duty, level}, {2'b00, 5'h13, 11'h7FF, 11'h0});
    av_xfer(1'b1, HOFS_CTRL, 32'h3);
    dev_cmd(1'b0, OFS_MODE, 8'h00);
    check(32'(st[2]), 32'h1);
    check(32'(dev_state), 32'(ST_STBY));
    cycles(WAIT_SHORT + 4);
    for (int i = 0; i < 6; i++) begin
      dev_cmd(REG_ROWS[i][24], REG_ROWS[i][23:16], REG_ROWS[i][15:8]);
      if (!REG_ROWS[i][24]) check(32'(st[15:8]), 32'(REG_ROWS[i][7:0]));
    end
    check(32'(fs_code), 32'h0A);
    // Period and active counts are even so the half-rate sampler sees exact counts
    for (int i = 0; i < 8; i++) begin
      dev_cmd(1'b1, OFS_PWM, DIM_ROWS[i][42:35]);
      av_xfer(1'b1, HOFS_PERIOD, 32'(DIM_ROWS[i][34:23]));
      av_xfer(1'b1, HOFS_HIGH, 32'(DIM_ROWS[i][22:11]));
      cycles(3 * int'(DIM_ROWS[i][34:23]) + 100);
      check(32'(duty), 32'(DIM_ROWS[i][10:0]));
    end
    // Backlight on, ramp slope for two ramp codes
    dev_cmd(1'b1, OFS_MODE, 8'h99);
    check(32'({led_enable, dev_state}), 32'({1'b1, ST_ACTIVE}));
    check(32'(fs_code), 32'h13);
    lv = 32'(level);
    cycles(200);
    check(32'(level) - lv, 32'd20);
    dev_cmd(1'b1, OFS_RAMP, 8'h10);
    lv = 32'(level);
    cycles(200);
    check(32'(level) - lv, 32'd10);
    // Backlight off: ramp down while the link stays alive
    dev_cmd(1'b1, OFS_MODE, 8'h98);
    check(32'(dev_state), 32'(ST_RAMPDN));
    dev_cmd(1'b0, OFS_MODE, 8'h00);
    check(32'(st[15:8]), 32'h98);
    k = 0;
    while (dev_state !== ST_STBY && k < 3000) begin
      cycles(1);
      k++;
    end
    check({dev_state, level}, {ST_STBY, 11'h0});
    // Enable dropped while lit: current cut with no ramp
    dev_cmd(1'b1, OFS_MODE, 8'h99);
    cycles(300);
    check(32'(level != 11'h0), 32'h1);
    av_xfer(1'b1, HOFS_CTRL, 32'h2);
    cycles(2);
    check(32'(level), 32'h0);
    check({bus_enabled, dev_state}, {1'b0, ST_SHUT});
    dev_cmd(1'b0, OFS_MODE, 8'h00);
    check(32'(st[2]), 32'h1);
    // Back on: registers are at defaults again
    av_xfer(1'b1, HOFS_CTRL, 32'h3);
    cycles(WAIT_SHORT + 4);
    dev_cmd(1'b0, OFS_MODE, 8'h00);
    check(32'(st[15:8]), 32'h98);
    check(32'(st[2]), 32'h0);
    print_verdict;
  end
endmodule // backlight_enable_pwm_dimming_tb
